/* rtl/sti_target.sv */
`timescale 1ns/1ns
`default_nettype none

module sti_glitch_filter (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic raw, // Line from the pin.
    output logic filt // Synchronised, spike-free level.
);
    logic meta_q;
    logic sync_q;
    logic [3:0] cnt_q;

    // The line idles high through its pull-up, so reset to high.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end

    // A new level must outlast the spike width before it is accepted.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt <= 1'b1;
            cnt_q <= 4'h0;
        end else if (sync_q == filt) begin
            cnt_q <= 4'h0;
        end else if (cnt_q == 4'(sti_pkg::SPIKE_CYCLES)) begin
            filt <= sync_q;
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule // sti_glitch_filter

// Behaviour
// - Act as bus target up to 1 MHz serial clock, all three speed classes.
// - Each byte takes nine clocks: eight data bits, then acknowledge.
// - Drive data on reads and acknowledge on writes, release otherwise.
// - Ignore spikes of 50 ns or less on clock and data.
// - Pull interrupt and/or reset outputs low when a rail leaves its window.
// - Reset defaults: OV/UV interrupts on, 1 ms timeout, self-test, 102.4 us.
// - Three channels, each off, OV only, UV only or window.
// - Thresholds start at factory values, host may overwrite them.
module sti_target (
    input wire logic CLOCK, // 10 MHz system clock.
    input wire logic RESET_N, // Asynchronous reset, active low.
    input wire logic SCL_IN, // Serial clock level from the host.
    input wire logic SDA_IN, // Serial data line level.
    output logic SDA_OUT, // Data line drive value, always low.
    output logic SDA_OE_N, // Low while pulling the data line low.
    input wire logic [2:0] OV_DETECT, // Per-channel overvoltage comparator.
    input wire logic [2:0] UV_DETECT, // Per-channel undervoltage comparator.
    output logic FAULT_INTERRUPT_OUT_N, // Fault interrupt, active low.
    output logic FAULT_RESET_OUT_N, // Fault reset, active low.
    output logic [5:0] CH_MODE, // Two mode bits per channel.
    output logic OV_INT_EN, // Overvoltage interrupt enable.
    output logic UV_INT_EN, // Undervoltage interrupt enable.
    output logic [7:0] SEQ_TIMEOUT_CODE, // Sequence timeout setting.
    output logic POWER_ON_SELF_TEST, // Self-test at power-on enable.
    output logic [7:0] DEBOUNCE_CODE, // OV/UV debounce setting.
    output logic [23:0] UV_THRESHOLDS, // Channel 2..0 UV thresholds.
    output logic [23:0] OV_THRESHOLDS // Channel 2..0 OV thresholds.
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } sti_state_t;

    logic scl_f;
    logic sda_f;
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    sti_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic read_q;
    logic first_q;
    logic [3:0] ptr_q;
    logic drive_q;
    logic [7:0] regs_q [0:sti_pkg::NUM_RW_REGS-1];
    logic [5:0] det_meta_q;
    logic [5:0] det_sync_q;
    logic [2:0] ch_fault;
    logic irq_n_q;
    logic rst_n_q;
    logic [7:0] rd_byte;

    sti_glitch_filter u_scl_filt (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .raw(SCL_IN),
        .filt(scl_f)
    );
    sti_glitch_filter u_sda_filt (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .raw(SDA_IN),
        .filt(sda_f)
    );

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_f;
            sda_prev_q <= sda_f;
        end
    end

    // The clock is only observed; ten samples per period at 1 MHz.
    assign scl_rise = scl_f && !scl_prev_q;
    assign scl_fall = !scl_f && scl_prev_q;
    assign start_det = scl_f && scl_prev_q && sda_prev_q && !sda_f;
    assign stop_det = scl_f && scl_prev_q && !sda_prev_q && sda_f;

    always_comb begin
        rd_byte = 8'h00;
        if (ptr_q == sti_pkg::REG_STATUS) begin
            rd_byte = {2'h0, det_sync_q};
        end else if (ptr_q < 4'(sti_pkg::NUM_RW_REGS)) begin
            rd_byte = regs_q[ptr_q];
        end
    end

    // Protocol engine; bits are sampled on rising clock, driven on falling.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            read_q <= 1'b0;
            first_q <= 1'b0;
            drive_q <= 1'b0;
        end else if (start_det) begin
            state_q <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            drive_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= ST_IDLE;
            drive_q <= 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_f};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        if (state_q == ST_WR) begin
                            drive_q <= 1'b1;
                            state_q <= ST_WR_ACK;
                        end else if (shift_q[7:1] == sti_pkg::TARGET_ADDR) begin
                            drive_q <= 1'b1;
                            read_q <= shift_q[0];
                            first_q <= 1'b1;
                            state_q <= ST_ADDR_ACK;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_WR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == ST_WR_ACK) begin
                            first_q <= 1'b0;
                        end
                        if (state_q == ST_ADDR_ACK && read_q) begin
                            shift_q <= rd_byte;
                            drive_q <= !rd_byte[7];
                            state_q <= ST_RD;
                        end else begin
                            drive_q <= 1'b0;
                            state_q <= ST_WR;
                        end
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_q == 4'h8) begin
                            drive_q <= 1'b0;
                            state_q <= ST_RD_ACK;
                        end else begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            drive_q <= !shift_q[6];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        // A not-acknowledge ends the read; wait for stop.
                        if (sda_f) begin
                            state_q <= ST_IDLE;
                        end
                    end else if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        shift_q <= rd_byte;
                        drive_q <= !rd_byte[7];
                        state_q <= ST_RD;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    drive_q <= 1'b0;
                end
            endcase
        end
    end
    // Pointer: first written byte loads it, each later written or acknowledged read byte advances it.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ptr_q <= 4'h0;
        end else if (state_q == ST_WR && scl_fall && bit_cnt_q == 4'h8) begin
            ptr_q <= first_q ? shift_q[3:0] : ptr_q + 4'h1;
        end else if (state_q == ST_RD_ACK && scl_rise && !sda_f) begin
            ptr_q <= ptr_q + 4'h1;
        end
    end
    // Writes past the writable range, including status, are dropped.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            regs_q[sti_pkg::REG_CH_MODE] <= sti_pkg::RST_CH_MODE;
            regs_q[sti_pkg::REG_INT_CFG] <= sti_pkg::RST_INT_CFG;
            regs_q[sti_pkg::REG_SEQ_TOUT] <= sti_pkg::RST_SEQ_TOUT;
            regs_q[sti_pkg::REG_TEST_CFG] <= sti_pkg::RST_TEST_CFG;
            regs_q[sti_pkg::REG_DEBOUNCE] <= sti_pkg::RST_DEBOUNCE;
            for (int i = 0; i < sti_pkg::NUM_CH; i++) begin
                regs_q[32'(sti_pkg::REG_UV_TH0) + i] <= sti_pkg::FACTORY_UV_TH;
                regs_q[32'(sti_pkg::REG_OV_TH0) + i] <= sti_pkg::FACTORY_OV_TH;
            end
        end else if (state_q == ST_WR && scl_fall && bit_cnt_q == 4'h8 &&
                     !first_q && ptr_q < 4'(sti_pkg::NUM_RW_REGS)) begin
            regs_q[ptr_q] <= shift_q;
        end
    end

    // Comparator flags come from the analog side, so they are synchronised.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            det_meta_q <= 6'h00;
            det_sync_q <= 6'h00;
        end else begin
            det_meta_q <= {UV_DETECT, OV_DETECT};
            det_sync_q <= det_meta_q;
        end
    end
    generate
        for (genvar c = 0; c < sti_pkg::NUM_CH; c++) begin : g_ch
            assign ch_fault[c] =
                (det_sync_q[c] && regs_q[sti_pkg::REG_CH_MODE][2*c] &&
                 OV_INT_EN) ||
                (det_sync_q[sti_pkg::NUM_CH+c] &&
                 regs_q[sti_pkg::REG_CH_MODE][2*c+1] && UV_INT_EN);
        end
    endgenerate
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_n_q <= 1'b1;
            rst_n_q <= 1'b1;
        end else begin
            irq_n_q <= !(|ch_fault &&
                regs_q[sti_pkg::REG_INT_CFG][sti_pkg::INT_TO_IRQ_BIT]);
            rst_n_q <= !(|ch_fault &&
                regs_q[sti_pkg::REG_INT_CFG][sti_pkg::INT_TO_RST_BIT]);
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE_N = !drive_q;
    assign FAULT_INTERRUPT_OUT_N = irq_n_q;
    assign FAULT_RESET_OUT_N = rst_n_q;
    assign CH_MODE = regs_q[sti_pkg::REG_CH_MODE][5:0];
    assign OV_INT_EN = regs_q[sti_pkg::REG_INT_CFG][sti_pkg::INT_OV_EN_BIT];
    assign UV_INT_EN = regs_q[sti_pkg::REG_INT_CFG][sti_pkg::INT_UV_EN_BIT];
    assign SEQ_TIMEOUT_CODE = regs_q[sti_pkg::REG_SEQ_TOUT];
    assign POWER_ON_SELF_TEST =
        regs_q[sti_pkg::REG_TEST_CFG][sti_pkg::TEST_POR_BIT];
    assign DEBOUNCE_CODE = regs_q[sti_pkg::REG_DEBOUNCE];
    assign UV_THRESHOLDS = {regs_q[7], regs_q[6], regs_q[5]};
    assign OV_THRESHOLDS = {regs_q[10], regs_q[9], regs_q[8]};
endmodule // sti_target

`default_nettype wire

/* rtl/sti_pkg.sv */
package sti_pkg;
    // Timing.
    localparam int CLK_PERIOD_NS = 100;
    localparam int SPIKE_NS = 50;
    localparam int SPIKE_CYCLES_RAW = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPIKE_CYCLES = (SPIKE_CYCLES_RAW < 1) ? 1 : SPIKE_CYCLES_RAW;
    localparam int SCL_MAX_KHZ = 1000;

    // Bus address of this target.
    localparam logic [6:0] TARGET_ADDR = 7'h30;

    // Register indexes.
    localparam logic [3:0] REG_CH_MODE = 4'h0;
    localparam logic [3:0] REG_INT_CFG = 4'h1;
    localparam logic [3:0] REG_SEQ_TOUT = 4'h2;
    localparam logic [3:0] REG_TEST_CFG = 4'h3;
    localparam logic [3:0] REG_DEBOUNCE = 4'h4;
    localparam logic [3:0] REG_UV_TH0 = 4'h5;
    localparam logic [3:0] REG_OV_TH0 = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hb;
    localparam int NUM_RW_REGS = 11;
    localparam int NUM_CH = 3;

    // Field positions.
    localparam int INT_OV_EN_BIT = 0;
    localparam int INT_UV_EN_BIT = 1;
    localparam int INT_TO_IRQ_BIT = 2;
    localparam int INT_TO_RST_BIT = 3;
    localparam int TEST_POR_BIT = 0;

    // Channel modes, two bits per channel.
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_OV_ONLY = 2'h1;
    localparam logic [1:0] MODE_UV_ONLY = 2'h2;
    localparam logic [1:0] MODE_WINDOW = 2'h3;

    // Reset values.
    localparam logic [7:0] RST_CH_MODE = 8'h3f;
    localparam logic [7:0] RST_INT_CFG = 8'h0f;
    localparam logic [7:0] RST_SEQ_TOUT = 8'h01; // Code for 1 ms.
    localparam logic [7:0] RST_TEST_CFG = 8'h01;
    localparam logic [7:0] RST_DEBOUNCE = 8'h0a; // Code for 102.4 us.
    localparam logic [7:0] FACTORY_UV_TH = 8'h40;
    localparam logic [7:0] FACTORY_OV_TH = 8'hc0;
endpackage

/* testbench/sti_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sti_host_model (
    input wire logic clk, // System clock paces the bus.
    input wire logic sda, // Resolved data line.
    output logic scl, // Bus clock, driven by the host alone.
    output logic sda_drv // Data drive, one means released.
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Low for five cycles, high for three: an 800 ns bus clock.
    task automatic bit_io(input logic b, output logic r);
        @(posedge clk) sda_drv <= b;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk) r = sda;
        @(posedge clk) scl <= 1'b0;
    endtask
    task automatic start();
        @(posedge clk) sda_drv <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_drv <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
    endtask
    task automatic stop();
        @(posedge clk) sda_drv <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_drv <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    // One-cycle clock pulse that a spike filter must swallow.
    task automatic spike();
        @(posedge clk) scl <= 1'b1;
        @(posedge clk) scl <= 1'b0;
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
    // Clock with the line released until it reads high or 18 clocks have run; n counts clocks.
    task automatic recover(output int n);
        logic r;
        n = 0;
        r = 1'b0;
        while (r !== 1'b1 && n < 18) begin
            bit_io(1'b1, r);
            n++;
        end
    endtask
endmodule // sti_host_model
`default_nettype wire

/* testbench/sti_target_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module sti_target_properties (
    input wire logic CLOCK, // System clock.
    input wire logic RESET_N, // Reset, active low.
    input wire logic SCL_IN, // Bus clock pin.
    input wire logic SDA_IN, // Bus data pin.
    input wire logic SDA_OUT, // Data drive value.
    input wire logic SDA_OE_N, // Data drive enable.
    input wire logic [2:0] OV_DETECT, // Overvoltage flags.
    input wire logic [2:0] UV_DETECT, // Undervoltage flags.
    input wire logic FAULT_INTERRUPT_OUT_N, // Fault interrupt.
    input wire logic FAULT_RESET_OUT_N, // Fault reset.
    input wire logic [5:0] CH_MODE, // Channel modes.
    input wire logic OV_INT_EN, // Overvoltage enable.
    input wire logic UV_INT_EN, // Undervoltage enable.
    input wire logic [7:0] SEQ_TIMEOUT_CODE, // Timeout code.
    input wire logic POWER_ON_SELF_TEST, // Self-test enable.
    input wire logic [7:0] DEBOUNCE_CODE, // Debounce code.
    input wire logic [23:0] UV_THRESHOLDS, // Undervoltage levels.
    input wire logic [23:0] OV_THRESHOLDS // Overvoltage levels.
);
    logic cause;
    logic [24:0] cfg;
    assign cause = |((OV_DETECT & {CH_MODE[4], CH_MODE[2], CH_MODE[0]}
        & {3{OV_INT_EN}}) | (UV_DETECT & {CH_MODE[5], CH_MODE[3],
        CH_MODE[1]} & {3{UV_INT_EN}}));
    assign cfg = {CH_MODE, OV_INT_EN, UV_INT_EN, SEQ_TIMEOUT_CODE,
        POWER_ON_SELF_TEST, DEBOUNCE_CODE};
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    a_drive_value_low: assert property (SDA_OUT == 1'b0)
        else $error("Data drive value is not low.");
    a_idle_line_free: assert property (SCL_IN [*8] |-> SDA_OE_N)
        else $error("Data line held while the bus clock idles.");
    a_oe_clock_low: assert property (
        $changed(SDA_OE_N) |-> !$past(SCL_IN, 2))
        else $error("Data drive moved outside a clock low phase.");
    a_irq_has_cause: assert property (
        !FAULT_INTERRUPT_OUT_N |-> $past(cause, 3))
        else $error("Interrupt low without an enabled fault.");
    a_rst_has_cause: assert property (
        !FAULT_RESET_OUT_N |-> $past(cause, 3))
        else $error("Reset output low without an enabled fault.");
    a_cfg_defaults: assert property ($rose(RESET_N) |->
        cfg == {sti_pkg::RST_CH_MODE[5:0], sti_pkg::RST_INT_CFG[0],
        sti_pkg::RST_INT_CFG[1], sti_pkg::RST_SEQ_TOUT,
        sti_pkg::RST_TEST_CFG[0], sti_pkg::RST_DEBOUNCE})
        else $error("Configuration not at defaults after reset.");
    a_thr_defaults: assert property ($rose(RESET_N) |->
        UV_THRESHOLDS == {3{sti_pkg::FACTORY_UV_TH}} &&
        OV_THRESHOLDS == {3{sti_pkg::FACTORY_OV_TH}})
        else $error("Thresholds not at factory values after reset.");
    a_cfg_clock_low: assert property (
        !$stable(cfg) |-> !$past(SCL_IN, 2))
        else $error("Configuration changed outside a clock low phase.");
    a_thr_clock_low: assert property (
        !$stable({UV_THRESHOLDS, OV_THRESHOLDS}) |-> !$past(SCL_IN, 2))
        else $error("Threshold changed outside a clock low phase.");
endmodule // sti_target_properties
`default_nettype wire

/* testbench/tb_sti_target.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_sti_target;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] ov = 3'h0;
    logic [2:0] uv = 3'h0;
    logic scl, sda_drv, sda_oe_n, sda_out, irq_n, frst_n, ov_en, uv_en, post;
    logic [5:0] mode, hit;
    logic [7:0] seq, deb;
    logic [23:0] uv_th, ov_th, q;
    logic a;
    wire logic sda = sda_drv & sda_oe_n;
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    int clocks = 0;
    sti_target u_sti_target (.CLOCK(clock), .RESET_N(reset_n), .SCL_IN(scl),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
        .OV_DETECT(ov), .UV_DETECT(uv), .FAULT_INTERRUPT_OUT_N(irq_n),
        .FAULT_RESET_OUT_N(frst_n), .CH_MODE(mode), .OV_INT_EN(ov_en),
        .UV_INT_EN(uv_en), .SEQ_TIMEOUT_CODE(seq),
        .POWER_ON_SELF_TEST(post), .DEBOUNCE_CODE(deb),
        .UV_THRESHOLDS(uv_th), .OV_THRESHOLDS(ov_th));
    sti_host_model u_sti_host_model (.clk(clock), .sda(sda), .scl(scl),
        .sda_drv(sda_drv));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clock) reset_n <= 1'b0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask
    task automatic check_defaults();
        check(mode, sti_pkg::RST_CH_MODE[5:0]);
        check({uv_en, ov_en}, 2'h3);
        check({post, seq, deb}, {1'b1, sti_pkg::RST_SEQ_TOUT,
            sti_pkg::RST_DEBOUNCE});
        check(uv_th, {3{sti_pkg::FACTORY_UV_TH}});
        check(ov_th, {3{sti_pkg::FACTORY_OV_TH}});
    endtask
    task automatic send(input logic [7:0] d, input logic exp);
        u_sti_host_model.put(d, a);
        check(a, exp);
    endtask
    task automatic wr(input logic [3:0] ptr, input logic [23:0] d,
        input int n, input logic sp);
        u_sti_host_model.start();
        send({sti_pkg::TARGET_ADDR, 1'b0}, 1'b0);
        send({4'h0, ptr}, 1'b0);
        if (sp) u_sti_host_model.spike();
        for (int i = 0; i < n; i++) send(d[8*i+:8], 1'b0);
        u_sti_host_model.stop();
    endtask
    task automatic rd(input logic [3:0] ptr, input int n);
        logic [7:0] b;
        u_sti_host_model.start();
        send({sti_pkg::TARGET_ADDR, 1'b0}, 1'b0);
        send({4'h0, ptr}, 1'b0);
        u_sti_host_model.start();
        send({sti_pkg::TARGET_ADDR, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) begin
            u_sti_host_model.get(i == n - 1, b);
            q[8*i+:8] = b;
        end
        u_sti_host_model.stop();
    endtask
    always #50 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        do_reset();
        check_defaults();
        // A foreign address must leave every later byte unanswered.
        u_sti_host_model.start();
        send(8'h62, 1'b1);
        send(8'h00, 1'b1);
        send(8'h00, 1'b1);
        u_sti_host_model.stop();
        check(mode, sti_pkg::RST_CH_MODE[5:0]);
        wr(sti_pkg::REG_UV_TH0, 24'h776655, 3, 1'b1);
        check(uv_th, 24'h776655);
        rd(sti_pkg::REG_UV_TH0, 3);
        check(q, 24'h776655);
        wr(sti_pkg::REG_CH_MODE, 24'h39, 1, 1'b0);
        check(mode, 6'h39);
        for (int i = 0; i < 6; i++) begin
            hit = 6'h1 << i;
            ov <= {hit[4], hit[2], hit[0]};
            uv <= {hit[5], hit[3], hit[1]};
            repeat (6) @(posedge clock);
            check({irq_n, frst_n}, {2{(hit & 6'h39) == 6'h0}});
            ov <= 3'h0;
            uv <= 3'h0;
            repeat (6) @(posedge clock);
            check({irq_n, frst_n}, 2'h3);
        end
        // A read left mid-byte: status is zero, so the line frees at clock 9.
        u_sti_host_model.start();
        send({sti_pkg::TARGET_ADDR, 1'b0}, 1'b0);
        send({4'h0, sti_pkg::REG_STATUS}, 1'b0);
        u_sti_host_model.start();
        send({sti_pkg::TARGET_ADDR, 1'b1}, 1'b0);
        u_sti_host_model.recover(clocks);
        u_sti_host_model.stop();
        check(clocks, 9);
        wr(sti_pkg::REG_INT_CFG, 24'h0e, 1, 1'b0);
        check({uv_en, ov_en}, 2'h2);
        ov <= 3'h1;
        repeat (6) @(posedge clock);
        check(irq_n, 1'b1);
        rd(sti_pkg::REG_STATUS, 1);
        check(q[7:0], 8'h01);
        ov <= 3'h0;
        do_reset();
        check_defaults();
        end_of_test();
    end
endmodule // tb_sti_target
bind sti_target sti_target_properties u_sti_target_properties (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .OV_DETECT(OV_DETECT),
    .UV_DETECT(UV_DETECT), .FAULT_INTERRUPT_OUT_N(FAULT_INTERRUPT_OUT_N),
    .FAULT_RESET_OUT_N(FAULT_RESET_OUT_N), .CH_MODE(CH_MODE),
    .OV_INT_EN(OV_INT_EN), .UV_INT_EN(UV_INT_EN),
    .SEQ_TIMEOUT_CODE(SEQ_TIMEOUT_CODE),
    .POWER_ON_SELF_TEST(POWER_ON_SELF_TEST), .DEBOUNCE_CODE(DEBOUNCE_CODE),
    .UV_THRESHOLDS(UV_THRESHOLDS), .OV_THRESHOLDS(OV_THRESHOLDS));
`default_nettype wire
